//--- core/cstc_consts.svh
// Offsets, field positions, reset values and widths of the start/trip combiner
`ifndef CSTC_CONSTS_SVH
`define CSTC_CONSTS_SVH

`define CSTC_N_PROT 16
`define CSTC_N_EXTRA 8
`define CSTC_CNT_W 16
`define CSTC_TS_W 32
`define CSTC_N_EV 4

`define CSTC_OFF_CTRL 8'h00
`define CSTC_OFF_START_SEL 8'h04
`define CSTC_OFF_TRIP_SEL 8'h08
`define CSTC_OFF_STATUS 8'h0c
`define CSTC_OFF_START_CNT 8'h10
`define CSTC_OFF_TRIP_CNT 8'h14
`define CSTC_OFF_CNT_CLR 8'h18
`define CSTC_OFF_IRQ_STAT 8'h1c
`define CSTC_OFF_IRQ_CLR 8'h20
`define CSTC_OFF_IRQ_EN 8'h24
`define CSTC_OFF_TSTAMP 8'h28

`define CSTC_CTRL_FORCE_LSB 0
`define CSTC_CTRL_FORCE_MSB 1
`define CSTC_CTRL_FORCE_EN 2
`define CSTC_CTRL_FILT_LSB 4
`define CSTC_CTRL_FILT_MSB 7
`define CSTC_CTRL_RST 8'hf0

`define CSTC_EV_START_ON 0
`define CSTC_EV_START_OFF 1
`define CSTC_EV_TRIP_ON 2
`define CSTC_EV_TRIP_OFF 3

`define CSTC_CLR_START 0
`define CSTC_CLR_TRIP 1

`endif

//--- core/cstc_pkg.sv
// Types shared by the start/trip combiner
package cstc_pkg;

    typedef enum logic [1:0] {
        CSTC_COND_NORMAL = 2'h0,
        CSTC_COND_START = 2'h1,
        CSTC_COND_TRIP = 2'h2
    } cstc_cond_e;

    typedef enum logic [1:0] {
        CSTC_FORCE_NORMAL = 2'h0,
        CSTC_FORCE_START = 2'h1,
        CSTC_FORCE_TRIP = 2'h2
    } cstc_force_e;

endpackage : cstc_pkg

//--- core/cstc_edge.sv
// Transition detector producing on and off pulses for one combined output
module cstc_edge (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Watched level
    input wire logic level,
    // Transition pulses
    output logic on_pulse,
    output logic off_pulse
);

    logic prev_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level;
        end
    end

    assign on_pulse = level & ~prev_q;
    assign off_pulse = ~level & prev_q;

endmodule : cstc_edge

//--- core/cstc_top.sv
// Common start/trip combiner with forcing, events, counters and register port
`include "cstc_consts.svh"

module cstc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Protection function outputs
    input wire logic [`CSTC_N_PROT-1:0] prot_start,
    input wire logic [`CSTC_N_PROT-1:0] prot_trip,
    // User-assignable signal sources
    input wire logic [`CSTC_N_EXTRA-1:0] extra_start,
    input wire logic [`CSTC_N_EXTRA-1:0] extra_trip,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic we,
    input wire logic re,
    output logic [31:0] rdata,
    // Combined outputs
    output logic common_start,
    output logic common_trip,
    // Event record
    output logic evt_valid,
    output logic [`CSTC_N_EV-1:0] evt_flags,
    output logic [`CSTC_TS_W-1:0] evt_time,
    // Interrupt
    output logic irq
);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic cstc_pkg::cstc_cond_e cond_of(input logic s, input logic t);
        if (t) begin
            cond_of = cstc_pkg::CSTC_COND_TRIP;
        end else if (s) begin
            cond_of = cstc_pkg::CSTC_COND_START;
        end else begin
            cond_of = cstc_pkg::CSTC_COND_NORMAL;
        end
    endfunction : cond_of

    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [`CSTC_N_EXTRA-1:0] start_sel_q;
    logic [`CSTC_N_EXTRA-1:0] start_sel_d;
    logic [`CSTC_N_EXTRA-1:0] trip_sel_q;
    logic [`CSTC_N_EXTRA-1:0] trip_sel_d;
    logic start_q;
    logic start_d;
    logic trip_q;
    logic trip_d;
    logic [`CSTC_CNT_W-1:0] start_cnt_q;
    logic [`CSTC_CNT_W-1:0] start_cnt_d;
    logic [`CSTC_CNT_W-1:0] trip_cnt_q;
    logic [`CSTC_CNT_W-1:0] trip_cnt_d;
    logic [`CSTC_N_EV-1:0] irq_stat_q;
    logic [`CSTC_N_EV-1:0] irq_stat_d;
    logic [`CSTC_N_EV-1:0] irq_en_q;
    logic [`CSTC_N_EV-1:0] irq_en_d;
    logic [`CSTC_TS_W-1:0] ts_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic irq_q;
    logic evt_valid_q;
    logic [`CSTC_N_EV-1:0] evt_flags_q;
    logic [`CSTC_TS_W-1:0] evt_time_q;
    logic [`CSTC_TS_W-1:0] evt_time_d;

    // Register write decode
    wire wr_ctrl = we && hit(addr, `CSTC_OFF_CTRL);
    wire wr_start_sel = we && hit(addr, `CSTC_OFF_START_SEL);
    wire wr_trip_sel = we && hit(addr, `CSTC_OFF_TRIP_SEL);
    wire wr_cnt_clr = we && hit(addr, `CSTC_OFF_CNT_CLR);
    wire wr_irq_clr = we && hit(addr, `CSTC_OFF_IRQ_CLR);
    wire wr_irq_en = we && hit(addr, `CSTC_OFF_IRQ_EN);

    // Single static copy; there is deliberately no setting group select port
    assign ctrl_d = wr_ctrl ? wdata[7:0] : ctrl_q;
    assign start_sel_d = wr_start_sel ? wdata[`CSTC_N_EXTRA-1:0] : start_sel_q;
    assign trip_sel_d = wr_trip_sel ? wdata[`CSTC_N_EXTRA-1:0] : trip_sel_q;
    assign irq_en_d = wr_irq_en ? wdata[`CSTC_N_EV-1:0] : irq_en_q;

    // Forcing decode; code 3 falls back to the computed result
    wire force_en = ctrl_q[`CSTC_CTRL_FORCE_EN];
    wire [1:0] force_sel = ctrl_q[`CSTC_CTRL_FORCE_MSB:`CSTC_CTRL_FORCE_LSB];
    wire force_start = force_en && (force_sel == cstc_pkg::CSTC_FORCE_START);
    wire force_trip = force_en && (force_sel == cstc_pkg::CSTC_FORCE_TRIP);
    wire force_any = force_start || force_trip;

    // Plain OR, extra sources gated only by their select masks: other suppression happens upstream
    wire prot_start_any = |prot_start;
    wire prot_trip_any = |prot_trip;
    wire extra_start_any = |(extra_start & start_sel_q);
    wire extra_trip_any = |(extra_trip & trip_sel_q);
    wire start_raw = prot_start_any || extra_start_any;
    wire trip_raw = prot_trip_any || extra_trip_any;

    // Forced trip reports trip only, so the condition reads as trip
    assign start_d = force_any ? force_start : start_raw;
    assign trip_d = force_any ? force_trip : trip_raw;

    // Transition detection on both combined outputs
    wire [1:0] outs = {trip_q, start_q};
    wire [1:0] on_ev;
    wire [1:0] off_ev;
    wire [`CSTC_N_EV-1:0] ev_raw;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_edge
            cstc_edge u_edge (
                .clk(clk),
                .nrst(nrst),
                .level(outs[gi]),
                .on_pulse(on_ev[gi]),
                .off_pulse(off_ev[gi])
            );
            assign ev_raw[2*gi] = on_ev[gi];
            assign ev_raw[2*gi+1] = off_ev[gi];
        end
    endgenerate

    // Filter selects which transitions reach the event record
    wire [`CSTC_N_EV-1:0] ev_kept = ev_raw & ctrl_q[`CSTC_CTRL_FILT_MSB:`CSTC_CTRL_FILT_LSB];
    assign evt_time_d = (|ev_kept) ? ts_q : evt_time_q;

    // Counters: an increment in the clear cycle is kept as a count of one
    wire clr_start = wr_cnt_clr && wdata[`CSTC_CLR_START];
    wire clr_trip = wr_cnt_clr && wdata[`CSTC_CLR_TRIP];
    wire inc_start = ev_raw[`CSTC_EV_START_ON];
    wire inc_trip = ev_raw[`CSTC_EV_TRIP_ON];
    wire [`CSTC_CNT_W-1:0] cnt_one = `CSTC_CNT_W'h1;
    assign start_cnt_d = inc_start ? (clr_start ? cnt_one : start_cnt_q + cnt_one)
                                   : (clr_start ? '0 : start_cnt_q);
    assign trip_cnt_d = inc_trip ? (clr_trip ? cnt_one : trip_cnt_q + cnt_one)
                                 : (clr_trip ? '0 : trip_cnt_q);

    // Sticky interrupt status, new event beats a clear in the same cycle
    wire [`CSTC_N_EV-1:0] irq_clr_mask = wr_irq_clr ? wdata[`CSTC_N_EV-1:0] : '0;
    assign irq_stat_d = (irq_stat_q & ~irq_clr_mask) | ev_raw;

    // Read selection
    cstc_pkg::cstc_cond_e cond_now;
    assign cond_now = cond_of(start_q, trip_q);
    wire [31:0] status_word = {28'h0, trip_q, start_q, 2'(cond_now)};
    wire [31:0] rd_val =
        hit(addr, `CSTC_OFF_CTRL) ? {24'h0, ctrl_q} :
        hit(addr, `CSTC_OFF_START_SEL) ? {24'h0, start_sel_q} :
        hit(addr, `CSTC_OFF_TRIP_SEL) ? {24'h0, trip_sel_q} :
        hit(addr, `CSTC_OFF_STATUS) ? status_word :
        hit(addr, `CSTC_OFF_START_CNT) ? {16'h0, start_cnt_q} :
        hit(addr, `CSTC_OFF_TRIP_CNT) ? {16'h0, trip_cnt_q} :
        hit(addr, `CSTC_OFF_IRQ_STAT) ? {28'h0, irq_stat_q} :
        hit(addr, `CSTC_OFF_IRQ_EN) ? {28'h0, irq_en_q} :
        hit(addr, `CSTC_OFF_TSTAMP) ? ts_q :
        32'h0;
    assign rdata_d = re ? rd_val : 32'h0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `CSTC_CTRL_RST;
            start_sel_q <= '0;
            trip_sel_q <= '0;
            irq_en_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            start_sel_q <= start_sel_d;
            trip_sel_q <= trip_sel_d;
            irq_en_q <= irq_en_d;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            start_q <= 1'b0;
            trip_q <= 1'b0;
            start_cnt_q <= '0;
            trip_cnt_q <= '0;
            irq_stat_q <= '0;
            irq_q <= 1'b0;
        end else begin
            start_q <= start_d;
            trip_q <= trip_d;
            start_cnt_q <= start_cnt_d;
            trip_cnt_q <= trip_cnt_d;
            irq_stat_q <= irq_stat_d;
            irq_q <= |(irq_stat_d & irq_en_d);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ts_q <= '0;
            evt_valid_q <= 1'b0;
            evt_flags_q <= '0;
            evt_time_q <= '0;
            rdata_q <= 32'h0;
        end else begin
            ts_q <= ts_q + `CSTC_TS_W'h1;
            evt_valid_q <= |ev_kept;
            evt_flags_q <= ev_kept;
            evt_time_q <= evt_time_d;
            rdata_q <= rdata_d;
        end
    end

    // Registered outputs feed contacts and user logic without further gating
    assign common_start = start_q;
    assign common_trip = trip_q;
    assign evt_valid = evt_valid_q;
    assign evt_flags = evt_flags_q;
    assign evt_time = evt_time_q;
    assign rdata = rdata_q;
    assign irq = irq_q;

    start_or_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (prot_start_any && !force_any) |=> common_start
    ) else $error("Protection start did not raise common start");

    trip_or_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (prot_trip_any && !force_any) |=> common_trip
    ) else $error("Protection trip did not raise common trip");

    extra_start_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ((extra_start & start_sel_q) != '0 && !force_any) |=> common_start
    ) else $error("Selected extra start did not raise common start");

    extra_trip_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ((extra_trip & trip_sel_q) != '0 && !force_any) |=> common_trip
    ) else $error("Selected extra trip did not raise common trip");

    force_trip_a: assert property (
        @(posedge clk) disable iff (!nrst)
        force_trip |=> (common_trip && !common_start)
    ) else $error("Forced trip not shown on outputs");

    force_gate_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (!force_en && !start_raw && !trip_raw) |=> (!common_start && !common_trip)
    ) else $error("Force select acted while forcing disabled");

    force_static_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !wr_ctrl |=> $stable(ctrl_q)
    ) else $error("Force setting changed without a write");

    cond_read_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (re && hit(addr, `CSTC_OFF_STATUS)) |=> (rdata[1:0] == 2'($past(cond_now)))
    ) else $error("Condition read does not match outputs");

    trip_event_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ($rose(common_trip) && ctrl_q[`CSTC_CTRL_FILT_LSB+`CSTC_EV_TRIP_ON])
            |=> (evt_valid && evt_flags[`CSTC_EV_TRIP_ON])
    ) else $error("Trip on event missing");

    start_off_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ($fell(common_start) && !ctrl_q[`CSTC_CTRL_FILT_LSB+`CSTC_EV_START_OFF])
            |=> !evt_flags[`CSTC_EV_START_OFF]
    ) else $error("Filtered start off event recorded");

    evt_stamp_a: assert property (
        @(posedge clk) disable iff (!nrst)
        evt_valid |-> (evt_time == $past(ts_q))
    ) else $error("Event timestamp not taken in event cycle");

    start_count_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (inc_start && !clr_start) |=> (start_cnt_q == $past(start_cnt_q) + cnt_one)
    ) else $error("Start counter did not advance");

    trip_clear_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (clr_trip && !inc_trip) |=> (trip_cnt_q == '0)
    ) else $error("Trip counter not cleared");

    start_release_a: assert property (
        @(posedge clk) disable iff (!nrst)
        (!start_raw && !force_any) |=> !common_start
    ) else $error("Common start held without contributor");

    irq_level_a: assert property (
        @(posedge clk) disable iff (!nrst)
        ((irq_stat_q & irq_en_q) != '0) |-> irq
    ) else $error("Interrupt low with enabled status set");

endmodule : cstc_top

//--- bench/cstc_prot_model.sv
// Stand-in for the protection functions and user signal sources
module cstc_prot_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Answer speed and commanded levels {start, trip, extra start, extra trip}
    input wire logic slow,
    input wire logic [47:0] cmd,
    // Levels toward the combiner
    output logic [15:0] prot_start,
    output logic [15:0] prot_trip,
    output logic [7:0] extra_start,
    output logic [7:0] extra_trip
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [47:0] d1_q;
    logic [47:0] d2_q;
    // Slow mode adds a cycle, as a late protection program cycle would
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            d1_q <= '0;
            d2_q <= '0;
        end else begin
            d1_q <= cmd;
            d2_q <= d1_q;
        end
    end
    // Plain levels only; there is no blocking line toward the combiner
    assign {prot_start, prot_trip, extra_start, extra_trip} = slow ? d2_q : d1_q;
endmodule : cstc_prot_model

//--- bench/tb_top.sv
// Self-checking bench for the start/trip combiner
`include "cstc_consts.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic slow = 1'b0;
    logic [47:0] cmd = '0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0;
    logic we = 1'b0;
    logic re = 1'b0;
    logic [15:0] prot_start, prot_trip;
    logic [7:0] extra_start, extra_trip;
    logic [31:0] rdata, evt_time, v, t_on;
    logic common_start, common_trip, evt_valid, irq;
    logic [3:0] evt_flags;
    int fails = 0;
    int samples_checked = 0;

    always #50 clk = ~clk;

    cstc_prot_model far_end (.clk(clk), .nrst(nrst), .slow(slow), .cmd(cmd), .prot_start(prot_start),
        .prot_trip(prot_trip), .extra_start(extra_start), .extra_trip(extra_trip));

    cstc_top uut (.clk(clk), .nrst(nrst), .prot_start(prot_start), .prot_trip(prot_trip),
        .extra_start(extra_start), .extra_trip(extra_trip), .addr(addr), .wdata(wdata), .we(we), .re(re),
        .rdata(rdata), .common_start(common_start), .common_trip(common_trip), .evt_valid(evt_valid),
        .evt_flags(evt_flags), .evt_time(evt_time), .irq(irq));

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [47:0] pk(input logic [15:0] ps, pt, input logic [7:0] xs, xt);
        return {ps, pt, xs, xt};
    endfunction : pk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd

    task automatic rdck(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask : rdck

    // Commons one cycle after the far end moves, the record one cycle later
    task automatic step(input logic [47:0] c, input logic s, input logic t, input logic [3:0] fl);
        @(posedge clk);
        cmd <= c;
        repeat (2 + slow) @(posedge clk);
        @(negedge clk);
        chk(32'(common_start), 32'(s));
        chk(32'(common_trip), 32'(t));
        @(negedge clk);
        chk(32'(evt_valid), 32'(fl != 4'h0));
        chk(32'(evt_flags), 32'(fl));
    endtask : step

    task automatic fchk(input logic [7:0] ctrl, input logic s, input logic t, input logic [3:0] fl);
        wr(`CSTC_OFF_CTRL, {24'h0, ctrl});
        @(negedge clk);
        @(negedge clk);
        chk(32'(common_start), 32'(s));
        chk(32'(common_trip), 32'(t));
        @(negedge clk);
        chk(32'(evt_valid), 32'(fl != 4'h0));
        chk(32'(evt_flags), 32'(fl));
    endtask : fchk

    initial begin
        #1_000_000;
        fails++;
        results();
    end

    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rdck(`CSTC_OFF_CTRL, 32'hf0);
        rdck(`CSTC_OFF_STATUS, 32'h0);
        rdck(`CSTC_OFF_START_CNT, 32'h0);
        @(negedge clk);
        chk(rdata, 32'h0);
        for (int i = 0; i < 16; i++) begin
            step(pk(16'h1 << i, 16'h1 << i, 8'h0, 8'h0), 1'b1, 1'b1, 4'h5);
            t_on = evt_time;
            step(pk(16'h0, 16'h0, 8'h0, 8'h0), 1'b0, 1'b0, 4'ha);
            chk(evt_time - t_on, 32'h4);
        end
        // One contributor dropping while another holds must not release
        step(pk(16'h3, 16'h0, 8'h0, 8'h0), 1'b1, 1'b0, 4'h1);
        step(pk(16'h2, 16'h0, 8'h0, 8'h0), 1'b1, 1'b0, 4'h0);
        step(pk(16'h0, 16'h0, 8'h0, 8'h0), 1'b0, 1'b0, 4'h2);
        step(pk(16'h0, 16'h0, 8'hff, 8'hff), 1'b0, 1'b0, 4'h0);
        step(pk(16'h0, 16'h0, 8'h0, 8'h0), 1'b0, 1'b0, 4'h0);
        wr(`CSTC_OFF_START_SEL, 32'h80);
        wr(`CSTC_OFF_TRIP_SEL, 32'h01);
        step(pk(16'h0, 16'h0, 8'h7f, 8'hfe), 1'b0, 1'b0, 4'h0);
        step(pk(16'h0, 16'h0, 8'h80, 8'h00), 1'b1, 1'b0, 4'h1);
        rdck(`CSTC_OFF_STATUS, 32'h5);
        step(pk(16'h0, 16'h0, 8'h80, 8'h01), 1'b1, 1'b1, 4'h4);
        rdck(`CSTC_OFF_STATUS, 32'he);
        step(pk(16'h0, 16'h0, 8'h0, 8'h0), 1'b0, 1'b0, 4'ha);
        rdck(`CSTC_OFF_START_CNT, 32'd18);
        rdck(`CSTC_OFF_TRIP_CNT, 32'd17);
        wr(`CSTC_OFF_CNT_CLR, 32'h1);
        rdck(`CSTC_OFF_START_CNT, 32'h0);
        rdck(`CSTC_OFF_TRIP_CNT, 32'd17);
        wr(`CSTC_OFF_CNT_CLR, 32'h2);
        rdck(`CSTC_OFF_TRIP_CNT, 32'h0);
        // Forcing without its enable must leave the outputs alone
        fchk(8'hf1, 1'b0, 1'b0, 4'h0);
        fchk(8'hf5, 1'b1, 1'b0, 4'h1);
        fchk(8'hf6, 1'b0, 1'b1, 4'h6);
        fchk(8'hf7, 1'b0, 1'b0, 4'h8);
        fchk(8'hf0, 1'b0, 1'b0, 4'h0);
        step(pk(16'h1, 16'h0, 8'h0, 8'h0), 1'b1, 1'b0, 4'h1);
        fchk(8'hf6, 1'b0, 1'b1, 4'h6);
        rdck(`CSTC_OFF_STATUS, 32'ha);
        fchk(8'hf0, 1'b1, 1'b0, 4'h9);
        step(pk(16'h0, 16'h0, 8'h0, 8'h0), 1'b0, 1'b0, 4'h2);
        wr(`CSTC_OFF_CTRL, 32'h50);
        step(pk(16'h1, 16'h0, 8'h0, 8'h0), 1'b1, 1'b0, 4'h1);
        step(pk(16'h0, 16'h0, 8'h0, 8'h0), 1'b0, 1'b0, 4'h0);
        wr(`CSTC_OFF_CTRL, 32'hf0);
        rdck(`CSTC_OFF_START_CNT, 32'h4);
        rdck(`CSTC_OFF_TRIP_CNT, 32'h2);
        chk(32'(irq), 32'h0);
        rdck(`CSTC_OFF_IRQ_STAT, 32'hf);
        wr(`CSTC_OFF_IRQ_EN, 32'h4);
        @(negedge clk);
        chk(32'(irq), 32'h1);
        wr(`CSTC_OFF_IRQ_CLR, 32'h4);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        rdck(`CSTC_OFF_IRQ_STAT, 32'hb);
        step(pk(16'h0, 16'h0400, 8'h0, 8'h0), 1'b0, 1'b1, 4'h4);
        chk(32'(irq), 32'h1);
        wr(`CSTC_OFF_IRQ_CLR, 32'hf);
        step(pk(16'h0, 16'h0, 8'h0, 8'h0), 1'b0, 1'b0, 4'h8);
        chk(32'(irq), 32'h0);
        rdck(`CSTC_OFF_IRQ_STAT, 32'h8);
        rdck(`CSTC_OFF_IRQ_EN, 32'h4);
        wr(8'h34, 32'hffffffff);
        wr(`CSTC_OFF_STATUS, 32'hffffffff);
        rdck(8'h34, 32'h0);
        rdck(`CSTC_OFF_STATUS, 32'h0);
        rd(`CSTC_OFF_TSTAMP, v);
        rd(`CSTC_OFF_TSTAMP, t_on);
        chk(t_on - v, 32'h2);
        @(posedge clk);
        slow <= 1'b1;
        step(pk(16'h8000, 16'h0, 8'h0, 8'h0), 1'b1, 1'b0, 4'h1);
        step(pk(16'h0, 16'h0, 8'h0, 8'h0), 1'b0, 1'b0, 4'h2);
        rdck(`CSTC_OFF_START_CNT, 32'h5);
        results();
    end
endmodule : tb_top
